/* File: hw/rtf_map.svh */
// Constants for the resistor-to-frequency converter: widths, setup code fields and mode codes.
// Assumes inclusion by bare name from the converter's design files.
`ifndef RTF_MAP_SVH
`define RTF_MAP_SVH

// Data widths.
`define RTF_CNT_W 16
`define RTF_NIB_W 4
`define RTF_CODE_W 6
`define RTF_ADDR_W 8
`define RTF_NET_N 3

// Setup code bit positions.
`define RTF_BIT_REF 0
`define RTF_BIT_SENSOR 1
`define RTF_BIT_AUX 2
`define RTF_BIT_ENABLE 3
`define RTF_BIT_MODE_LO 4
`define RTF_BIT_MODE_HI 5

// Gate mode field values.
`define RTF_MODE_FIELD_SW 2'h0
`define RTF_MODE_FIELD_TIMER 2'h1
`define RTF_MODE_FIELD_EDGE 2'h2

// Reset values.
`define RTF_CNT_RST 16'h0000
`define RTF_CODE_RST 6'h00

`endif

/* File: hw/rtf_pkg.sv */
// Types shared by the resistor-to-frequency converter modules.
// Assumes nothing beyond a SystemVerilog compiler.
package rtf_pkg;

  // Gate mode of the counter.
  typedef enum logic [1:0] {
    RTF_MODE_SW,
    RTF_MODE_TIMER,
    RTF_MODE_EDGE
  } rtf_mode_t;

  // Counter sequencer state.
  typedef enum logic [1:0] {
    RTF_ST_IDLE,
    RTF_ST_ARMED,
    RTF_ST_COUNTING,
    RTF_ST_DONE
  } rtf_state_t;

endpackage

/* File: hw/rtf_edge_det.sv */
// Rising and falling edge detector for a signal already synchronous to clk.
// Assumes the input is sampled by clk; clk_en low freezes the history flop.
`timescale 1ns/1ps

module rtf_edge_det (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Watched level and its edges.
  input wire logic sig,
  output logic rise,
  output logic fall
);

  logic prev_reg;
  logic prev_next;

  // Next history value follows the input while enabled.
  always_comb begin
    prev_next = clk_en ? sig : prev_reg;
  end

  // History flop.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // Edges are only reported in enabled cycles.
  assign rise = clk_en & sig & ~prev_reg;
  assign fall = clk_en & ~sig & prev_reg;

endmodule // rtf_edge_det

/* File: hw/rtf_count16.sv */
// Sixteen-bit up counter with synchronous clear and a wrap pulse.
// Assumes clear and inc are single-cycle requests from the sequencer.
`timescale 1ns/1ps
`include "rtf_map.svh"

module rtf_count16 (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Control.
  input wire logic clear,
  input wire logic inc,
  // Result.
  output logic [`RTF_CNT_W-1:0] value,
  output logic wrap
);

  logic [`RTF_CNT_W-1:0] cnt_reg;
  logic [`RTF_CNT_W-1:0] cnt_next;

  // Clear has priority over counting; the sum wraps naturally.
  always_comb begin
    cnt_next = cnt_reg;
    if (clk_en && clear) begin
      cnt_next = `RTF_CNT_RST;
    end else if (clk_en && inc) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  // Count register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= `RTF_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign value = cnt_reg;
  // Wrap fires in the cycle that rolls the count from all ones to zero.
  assign wrap = clk_en & inc & ~clear & (&cnt_reg);

endmodule // rtf_count16

/* File: hw/rtf_top.sv */
// Resistor-to-frequency converter: network pin drivers, gated 16-bit counter and readout.
// Assumes setup and read strobes come from an instruction decoder as one-cycle pulses,
// all pin inputs are synchronous to clk, and the timer and generator live elsewhere.
`timescale 1ns/1ps
`include "rtf_map.svh"

// Behaviour
// - Three RC networks exist and at most one of them is ever enabled.
// - Setup codes 1h and 2h enable the reference and sensor pins, which float when disabled.
// - Codes 8h, 18h and 28h start the network and counter; before that enabled pins drive 0.
// - In software and timer modes the oscillator input edges clock the counter.
// - In software mode code 8h starts counting pin edges and code 0 stops it.
// - Four read instructions copy one part of the count to memory and the accumulator.
// - Every enable of the counter clears it to zero.
// - An overflow flag records that the count wrapped during the interval.
// - Code 9 enables the reference network and counter together; code 1 leaves it stopped.
// - Timer mode waits for the timer enable and a falling edge of its clock source.
// - Timer mode stops counting when the second timer underflows.
// - Edge mode uses the oscillator pin as gate and counts generator output edges.
// - Edge mode counting begins at the first oscillator rising edge after enabling.
// - Edge mode stops at the second rising edge and raises the halt-release request.
// - The request raises an interrupt if enabled; with halt release enabled it also releases halt and sets flag nine.
module rtf_top
  import rtf_pkg::*;
(
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Setup instruction.
  input wire logic converter_setup_instruction,
  input wire logic [`RTF_CODE_W-1:0] setup_code,
  // Count read instructions.
  input wire logic count_read_nibble0,
  input wire logic count_read_nibble1,
  input wire logic count_read_nibble2,
  input wire logic count_read_nibble3,
  input wire logic [`RTF_ADDR_W-1:0] read_addr,
  // Memory and accumulator write port.
  output logic mem_wr_en,
  output logic [`RTF_ADDR_W-1:0] mem_wr_addr,
  output logic [`RTF_NIB_W-1:0] read_data,
  // Oscillator input and network pins.
  input wire logic osc_schmitt_input_pin,
  output logic reference_resistor_pin_o,
  output logic reference_resistor_pin_oe,
  output logic sensor_resistor_pin_o,
  output logic sensor_resistor_pin_oe,
  output logic aux_network_pin_o,
  output logic aux_network_pin_oe,
  // Second down timer and generator.
  input wire logic second_down_timer_enable,
  input wire logic second_down_timer_clk_src,
  input wire logic second_down_timer_underflow,
  input wire logic generator_output_a,
  // Halt release and interrupt control.
  input wire logic counter_interrupt_enable,
  input wire logic counter_halt_release_enable,
  input wire logic halt_request_clear,
  input wire logic start_flag_clear,
  // Status.
  output logic counter_halt_release_request,
  output logic counter_interrupt_request,
  output logic halt_release_pulse,
  output logic start_condition_flag_nine,
  output logic count_overflow_flag,
  output logic counter_running
);

  // Picks the single network to enable: reference wins, then sensor, then aux.
  function automatic logic [`RTF_NET_N-1:0] pick_network(input logic [`RTF_CODE_W-1:0] code);
    logic [`RTF_NET_N-1:0] sel;
    sel = 3'h0;
    if (code[`RTF_BIT_REF]) begin
      sel = 3'h1;
    end else if (code[`RTF_BIT_SENSOR]) begin
      sel = 3'h2;
    end else if (code[`RTF_BIT_AUX]) begin
      sel = 3'h4;
    end
    return sel;
  endfunction

  // Decodes the gate mode field; the unused value acts as software gating.
  function automatic rtf_mode_t pick_mode(input logic [`RTF_CODE_W-1:0] code);
    rtf_mode_t m;
    case (code[`RTF_BIT_MODE_HI:`RTF_BIT_MODE_LO])
      `RTF_MODE_FIELD_TIMER: m = RTF_MODE_TIMER;
      `RTF_MODE_FIELD_EDGE: m = RTF_MODE_EDGE;
      default: m = RTF_MODE_SW;
    endcase
    return m;
  endfunction

  // Sequencer and configuration state.
  rtf_state_t state_reg;
  rtf_state_t state_next;
  rtf_mode_t mode_reg;
  rtf_mode_t mode_next;
  logic [`RTF_NET_N-1:0] net_sel_reg;
  logic [`RTF_NET_N-1:0] net_sel_next;
  logic osc_on_reg;
  logic osc_on_next;
  // Flags.
  logic ovf_reg;
  logic ovf_next;
  logic hrr_reg;
  logic hrr_next;
  logic scf_reg;
  logic scf_next;
  logic hrel_reg;
  logic hrel_next;
  // Readout.
  logic rd_en_reg;
  logic rd_en_next;
  logic [`RTF_ADDR_W-1:0] rd_addr_reg;
  logic [`RTF_ADDR_W-1:0] rd_addr_next;
  logic [`RTF_NIB_W-1:0] rd_data_reg;
  logic [`RTF_NIB_W-1:0] rd_data_next;
  // Pin drive values.
  logic [`RTF_NET_N-1:0] drive_reg;
  logic [`RTF_NET_N-1:0] drive_next;
  logic [`RTF_NET_N-1:0] pin_oe;
  // Internal strobes.
  logic osc_rise;
  logic osc_fall;
  logic gen_rise;
  logic tclk_fall;
  logic cnt_clear;
  logic cnt_inc;
  logic cnt_wrap;
  logic req_set;
  logic [`RTF_CNT_W-1:0] cnt_value;
  logic [1:0] rd_sel;
  logic rd_any;

  // Edge detectors for the oscillator, generator and timer clock source.
  rtf_edge_det u_osc_edge (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .sig(osc_schmitt_input_pin), .rise(osc_rise), .fall(osc_fall));

  rtf_edge_det u_gen_edge (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .sig(generator_output_a), .rise(gen_rise), .fall());

  rtf_edge_det u_tclk_edge (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .sig(second_down_timer_clk_src), .rise(), .fall(tclk_fall));

  // The counter itself.
  rtf_count16 u_count (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .clear(cnt_clear),
    .inc(cnt_inc), .value(cnt_value), .wrap(cnt_wrap));

  // Sequencer: setup decode, gate handling and the end-of-interval request.
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    net_sel_next = net_sel_reg;
    osc_on_next = osc_on_reg;
    cnt_clear = 1'b0;
    cnt_inc = 1'b0;
    req_set = 1'b0;
    if (clk_en) begin
      // Count sources differ by mode; edge mode counts the generator.
      if (state_reg == RTF_ST_COUNTING) begin
        if (mode_reg == RTF_MODE_EDGE) begin
          cnt_inc = gen_rise;
        end else begin
          cnt_inc = osc_rise;
        end
      end
      case (state_reg)
        RTF_ST_ARMED: begin
          if (mode_reg == RTF_MODE_TIMER) begin
            if (second_down_timer_enable && tclk_fall) begin
              state_next = RTF_ST_COUNTING;
            end
          end else if (osc_rise) begin
            state_next = RTF_ST_COUNTING;
          end
        end
        RTF_ST_COUNTING: begin
          if (mode_reg == RTF_MODE_TIMER && second_down_timer_underflow) begin
            state_next = RTF_ST_DONE;
            cnt_inc = 1'b0;
          end else if (mode_reg == RTF_MODE_EDGE && osc_rise) begin
            state_next = RTF_ST_DONE;
            cnt_inc = 1'b0;
            req_set = 1'b1;
          end
        end
        // Idle and done hold until the next setup instruction.
        default: begin
          state_next = state_reg;
        end
      endcase
      // A setup instruction overrides the gate's state and count; a same-cycle edge-mode stop still sets the request.
      if (converter_setup_instruction) begin
        net_sel_next = pick_network(setup_code);
        mode_next = pick_mode(setup_code);
        cnt_inc = 1'b0;
        if (setup_code[`RTF_BIT_ENABLE]) begin
          osc_on_next = 1'b1;
          cnt_clear = 1'b1;
          // Software gating starts at once; the other modes wait for their gate.
          if (pick_mode(setup_code) == RTF_MODE_SW) begin
            state_next = RTF_ST_COUNTING;
          end else begin
            state_next = RTF_ST_ARMED;
          end
        end else begin
          osc_on_next = 1'b0;
          state_next = RTF_ST_IDLE;
        end
      end
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= RTF_ST_IDLE;
      mode_reg <= RTF_MODE_SW;
      net_sel_reg <= 3'h0;
      osc_on_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      net_sel_reg <= net_sel_next;
      osc_on_reg <= osc_on_next;
    end
  end

  // Flags: a hardware set in the same cycle as a clear wins.
  always_comb begin
    ovf_next = ovf_reg;
    hrr_next = hrr_reg;
    scf_next = scf_reg;
    hrel_next = 1'b0;
    if (clk_en) begin
      if (cnt_clear) begin
        ovf_next = 1'b0;
      end else if (cnt_wrap) begin
        ovf_next = 1'b1;
      end
      hrr_next = req_set | (hrr_reg & ~halt_request_clear);
      scf_next = (req_set & counter_halt_release_enable) | (scf_reg & ~start_flag_clear);
      hrel_next = req_set & counter_halt_release_enable;
    end else begin
      hrel_next = hrel_reg;
    end
  end

  // Flag registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_reg <= 1'b0;
      hrr_reg <= 1'b0;
      scf_reg <= 1'b0;
      hrel_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_next;
      hrr_reg <= hrr_next;
      scf_reg <= scf_next;
      hrel_reg <= hrel_next;
    end
  end

  // Readout: pick the nibble named by the read instruction.
  assign rd_any = count_read_nibble0 | count_read_nibble1 | count_read_nibble2 |
    count_read_nibble3;
  always_comb begin
    rd_sel = 2'h3;
    if (count_read_nibble0) begin
      rd_sel = 2'h0;
    end else if (count_read_nibble1) begin
      rd_sel = 2'h1;
    end else if (count_read_nibble2) begin
      rd_sel = 2'h2;
    end
    rd_en_next = clk_en ? rd_any : rd_en_reg;
    rd_addr_next = rd_addr_reg;
    rd_data_next = rd_data_reg;
    if (clk_en && rd_any) begin
      rd_addr_next = read_addr;
      rd_data_next = cnt_value[rd_sel*`RTF_NIB_W +: `RTF_NIB_W];
    end
  end

  // Readout registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_en_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      rd_data_reg <= 4'h0;
    end else begin
      rd_en_reg <= rd_en_next;
      rd_addr_reg <= rd_addr_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // Network pins: enabled pin drives the inverted oscillator once started, else 0.
  generate
    for (genvar i = 0; i < `RTF_NET_N; i++) begin : g_net
      always_comb begin
        drive_next[i] = clk_en ? (osc_on_reg & net_sel_reg[i] & ~osc_schmitt_input_pin)
          : drive_reg[i];
      end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          drive_reg[i] <= 1'b0;
        end else begin
          drive_reg[i] <= drive_next[i];
        end
      end
      assign pin_oe[i] = net_sel_reg[i];
    end
  endgenerate

  // Pin and status outputs.
  assign reference_resistor_pin_o = drive_reg[`RTF_BIT_REF];
  assign reference_resistor_pin_oe = pin_oe[`RTF_BIT_REF];
  assign sensor_resistor_pin_o = drive_reg[`RTF_BIT_SENSOR];
  assign sensor_resistor_pin_oe = pin_oe[`RTF_BIT_SENSOR];
  assign aux_network_pin_o = drive_reg[`RTF_BIT_AUX];
  assign aux_network_pin_oe = pin_oe[`RTF_BIT_AUX];
  assign mem_wr_en = rd_en_reg;
  assign mem_wr_addr = rd_addr_reg;
  assign read_data = rd_data_reg;
  assign counter_halt_release_request = hrr_reg;
  assign counter_interrupt_request = hrr_reg & counter_interrupt_enable;
  assign halt_release_pulse = hrel_reg;
  assign start_condition_flag_nine = scf_reg;
  assign count_overflow_flag = ovf_reg;
  assign counter_running = (state_reg == RTF_ST_COUNTING);

endmodule // rtf_top

/* File: dv/rtf_top_checker.sv */
// Concurrent checks on the converter's top-level ports.
// Assumes a bind onto rtf_top, one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "rtf_map.svh"

module rtf_top_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Requests.
  input wire logic converter_setup_instruction,
  input wire logic [`RTF_CODE_W-1:0] setup_code,
  input wire logic count_read_nibble0,
  input wire logic count_read_nibble1,
  input wire logic count_read_nibble2,
  input wire logic count_read_nibble3,
  input wire logic [`RTF_ADDR_W-1:0] read_addr,
  input wire logic osc_schmitt_input_pin,
  input wire logic second_down_timer_underflow,
  input wire logic counter_interrupt_enable,
  // Answers.
  input wire logic mem_wr_en,
  input wire logic [`RTF_ADDR_W-1:0] mem_wr_addr,
  input wire logic reference_resistor_pin_o,
  input wire logic reference_resistor_pin_oe,
  input wire logic sensor_resistor_pin_o,
  input wire logic sensor_resistor_pin_oe,
  input wire logic aux_network_pin_o,
  input wire logic aux_network_pin_oe,
  input wire logic counter_halt_release_request,
  input wire logic counter_interrupt_request,
  input wire logic halt_release_pulse,
  input wire logic counter_running
);
  logic [1:0] mode_q;
  logic set_w;
  logic rd_w;
  logic any_oe;

  // Qualified requests and the combined pin enable.
  assign set_w = clk_en && converter_setup_instruction;
  assign rd_w = clk_en && (count_read_nibble0 || count_read_nibble1 || count_read_nibble2
    || count_read_nibble3);
  assign any_oe = reference_resistor_pin_oe || sensor_resistor_pin_oe || aux_network_pin_oe;

  // Remembers the gate mode given by the last setup.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 2'h0;
    end else if (set_w) begin
      mode_q <= setup_code[5:4];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_one_net;
    $onehot0({reference_resistor_pin_oe, sensor_resistor_pin_oe, aux_network_pin_oe});
  endproperty
  a_one_net: assert property (p_one_net) else $error("two networks driving");
  property p_ref_sel;
    set_w && setup_code[0] |=> reference_resistor_pin_oe;
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference pin not driven");
  property p_float;
    set_w && setup_code[2:0] == 3'h0 |=> !any_oe;
  endproperty
  a_float: assert property (p_float) else $error("pin driven with no network");
  property p_idle_zero;
    set_w && !setup_code[3] ##1 !set_w |=> !(reference_resistor_pin_o || sensor_resistor_pin_o
      || aux_network_pin_o);
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("pin high while stopped");
  property p_sw_run;
    set_w && setup_code[3] && setup_code[5:4] != 2'h1 && setup_code[5:4] != 2'h2
      |=> counter_running;
  endproperty
  a_sw_run: assert property (p_sw_run) else $error("software start missed");
  property p_stop;
    set_w && !setup_code[3] |=> !counter_running;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_armed;
    set_w && setup_code[3] && (setup_code[5:4] == 2'h1 || setup_code[5:4] == 2'h2)
      |=> !counter_running;
  endproperty
  a_armed: assert property (p_armed) else $error("gated mode ran early");
  property p_uf;
    mode_q == 2'h1 && counter_running && second_down_timer_underflow && !set_w
      |=> !counter_running;
  endproperty
  a_uf: assert property (p_uf) else $error("underflow did not stop");
  property p_edge_stop;
    mode_q == 2'h2 && counter_running && $rose(osc_schmitt_input_pin) && !set_w
      |=> !counter_running && counter_halt_release_request;
  endproperty
  a_edge_stop: assert property (p_edge_stop) else $error("second edge did not stop");
  property p_irq;
    counter_interrupt_request == (counter_halt_release_request && counter_interrupt_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request wrong");
  property p_pulse;
    halt_release_pulse && clk_en |=> !halt_release_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("halt release pulse too long");
  property p_read;
    rd_w |=> mem_wr_en && mem_wr_addr == $past(read_addr);
  endproperty
  a_read: assert property (p_read) else $error("read write-back wrong");

  c_edge: cover property ($rose(counter_halt_release_request));
  c_uf: cover property (mode_q == 2'h1 && counter_running ##1 !counter_running);
  c_rd: cover property (rd_w ##1 rd_w);
endmodule // rtf_top_checker

bind rtf_top rtf_top_checker u_chk (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
  .converter_setup_instruction(converter_setup_instruction), .setup_code(setup_code),
  .count_read_nibble0(count_read_nibble0), .count_read_nibble1(count_read_nibble1),
  .count_read_nibble2(count_read_nibble2), .count_read_nibble3(count_read_nibble3),
  .read_addr(read_addr), .osc_schmitt_input_pin(osc_schmitt_input_pin),
  .second_down_timer_underflow(second_down_timer_underflow),
  .counter_interrupt_enable(counter_interrupt_enable), .mem_wr_en(mem_wr_en),
  .mem_wr_addr(mem_wr_addr), .reference_resistor_pin_o(reference_resistor_pin_o),
  .reference_resistor_pin_oe(reference_resistor_pin_oe),
  .sensor_resistor_pin_o(sensor_resistor_pin_o), .sensor_resistor_pin_oe(sensor_resistor_pin_oe),
  .aux_network_pin_o(aux_network_pin_o), .aux_network_pin_oe(aux_network_pin_oe),
  .counter_halt_release_request(counter_halt_release_request),
  .counter_interrupt_request(counter_interrupt_request),
  .halt_release_pulse(halt_release_pulse), .counter_running(counter_running));

/* File: dv/rtf_rc_network.sv */
// Behavioural external RC networks charging the oscillator input node.
// Assumes pin outputs change on clk; the bench may take the node over.
`timescale 1ns/1ps

module rtf_rc_network #(
  parameter int DELAY = 3
) (
  // Clock.
  input wire logic clk,
  // Network drivers.
  input wire logic ref_o,
  input wire logic ref_oe,
  input wire logic sen_o,
  input wire logic sen_oe,
  input wire logic aux_o,
  input wire logic aux_oe,
  // Bench takeover of the node.
  input wire logic force_en,
  input wire logic force_lvl,
  // Capacitor node.
  output logic osc
);
  logic [7:0] rc_dly = 8'h00;
  logic drv;

  // The driving pin charges the node; an undriven node shows the inverse so misuse stands out.
  assign drv = ref_oe ? ref_o : sen_oe ? sen_o : aux_oe ? aux_o : ~osc;
  assign osc = force_en ? force_lvl : rc_dly[DELAY-1];

  // The RC time constant shows as a lag of DELAY cycles.
  always @(posedge clk) begin
    rc_dly <= {rc_dly[6:0], drv};
  end
endmodule // rtf_rc_network

/* File: dv/rtf_top_bench.sv */
// Self-checking bench for the converter with a reference model of the gated counter.
// Assumes rtf_top, its checker and the RC network model are compiled first.
`timescale 1ns/1ps

module rtf_top_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic setup = 1'b0;
  logic [5:0] code = 6'h00;
  logic [3:0] rd_n = 4'h0;
  logic [7:0] ra = 8'h00;
  logic tmr_en = 1'b0;
  logic tclk = 1'b0;
  logic uf = 1'b0;
  logic gen = 1'b0;
  logic ie = 1'b0;
  logic he = 1'b0;
  logic hclr = 1'b0;
  logic fclr = 1'b0;
  logic force_en = 1'b1;
  logic force_lvl = 1'b0;
  logic wr_en, ref_o, ref_oe, sen_o, sen_oe, aux_o, aux_oe, req, irq, hp, f9, ovf, running, osc;
  logic [7:0] wr_a;
  logic [3:0] rdata;
  logic [15:0] m_cnt;
  logic [1:0] m_st, m_md;
  logic m_req, m_f9, osc_q, gen_q, tclk_q;
  int err_count = 0;
  int tests_run = 0;
  int n;
  logic [5:0] n_codes [4] = '{6'h01, 6'h02, 6'h04, 6'h07};

  rtf_top dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .converter_setup_instruction(setup),
    .setup_code(code), .count_read_nibble0(rd_n[0]), .count_read_nibble1(rd_n[1]),
    .count_read_nibble2(rd_n[2]), .count_read_nibble3(rd_n[3]), .read_addr(ra),
    .mem_wr_en(wr_en), .mem_wr_addr(wr_a), .read_data(rdata), .osc_schmitt_input_pin(osc),
    .reference_resistor_pin_o(ref_o), .reference_resistor_pin_oe(ref_oe),
    .sensor_resistor_pin_o(sen_o), .sensor_resistor_pin_oe(sen_oe),
    .aux_network_pin_o(aux_o), .aux_network_pin_oe(aux_oe),
    .second_down_timer_enable(tmr_en), .second_down_timer_clk_src(tclk),
    .second_down_timer_underflow(uf), .generator_output_a(gen),
    .counter_interrupt_enable(ie), .counter_halt_release_enable(he),
    .halt_request_clear(hclr), .start_flag_clear(fclr), .counter_halt_release_request(req),
    .counter_interrupt_request(irq), .halt_release_pulse(hp), .start_condition_flag_nine(f9),
    .count_overflow_flag(ovf), .counter_running(running));
  rtf_rc_network u_net (.clk(clk), .ref_o(ref_o), .ref_oe(ref_oe), .sen_o(sen_o),
    .sen_oe(sen_oe), .aux_o(aux_o), .aux_oe(aux_oe), .force_en(force_en),
    .force_lvl(force_lvl), .osc(osc));

  // Clock at 40 MHz.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Reference model: state, count and flags advanced on the design's edges.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {m_cnt, m_st, m_md, m_req, m_f9, osc_q, gen_q, tclk_q} <= '0;
    end else if (clk_en) begin
      osc_q <= osc;
      gen_q <= gen;
      tclk_q <= tclk;
      if (hclr) m_req <= 1'b0;
      if (fclr) m_f9 <= 1'b0;
      if (setup) begin
        m_md <= code[5:4];
        m_st <= !code[3] ? 2'h0 : (code[5:4] == 2'h1 || code[5:4] == 2'h2) ? 2'h1 : 2'h2;
        if (code[3]) m_cnt <= 16'h0000;
      end else if (m_st == 2'h1 && (m_md == 2'h1 ? tmr_en && tclk_q && !tclk : osc && !osc_q)) begin
        m_st <= 2'h2;
      end else if (m_st == 2'h2 && (m_md == 2'h1 ? uf : m_md == 2'h2 && osc && !osc_q)) begin
        m_st <= 2'h3;
        if (m_md == 2'h2) m_req <= 1'b1;
        if (m_md == 2'h2 && he) m_f9 <= 1'b1;
      end else if (m_st == 2'h2 && (m_md == 2'h2 ? gen && !gen_q : osc && !osc_q)) begin
        m_cnt <= m_cnt + 16'h0001;
      end
    end
  end

  // Random generator and timer clock levels, plus a cycle-by-cycle comparison.
  always @(posedge clk) begin
    #2;
    gen = 1'($urandom);
    tclk = 1'($urandom);
    #1;
    if (rst_b) begin
      check(running, m_st == 2'h2, "running");
      check(req, m_req, "request");
      check(irq, m_req & ie, "interrupt");
      check(f9, m_f9, "flag nine");
    end
  end

  // Lowest selected network pin enable.
  function automatic logic [2:0] exp_oe(input logic [5:0] c);
    return c[0] ? 3'h1 : c[1] ? 3'h2 : c[2] ? 3'h4 : 3'h0;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  task automatic do_setup(input logic [5:0] c);
    setup = 1'b1;
    code = c;
    step(1);
    setup = 1'b0;
    step(1);
  endtask

  // Four back-to-back reads to random addresses.
  task automatic read_all();
    logic [7:0] a;
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom);
      rd_n = 4'h1 << i;
      ra = a;
      step(1);
      check(wr_en, 1'b1, "write strobe");
      check(wr_a, a, "write address");
      check(rdata, m_cnt[i*4 +: 4], "nibble");
    end
    rd_n = 4'h0;
    step(1);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog for a hung run.
  initial begin
    #(25 * 30000);
    err_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'hF489C17B));
    repeat (6) @(posedge clk);
    #2;
    rst_b = 1'b1;
    step(1);
    check({aux_oe, sen_oe, ref_oe, ovf}, 4'h0, "reset state");
    foreach (n_codes[j]) begin
      do_setup(n_codes[j]);
      step(3);
      check({aux_oe, sen_oe, ref_oe}, exp_oe(n_codes[j]), "pin enables");
      check({aux_o, sen_o, ref_o}, 3'h0, "pins before enable");
    end
    force_en = 1'b0;
    for (int k = 0; k < 4; k++) begin
      n = k == 0 ? 1 : 1 << ($urandom % 3);
      do_setup(6'(n));
      do_setup(6'(n) | 6'h08 | (k == 3 ? 6'h30 : 6'h00));
      step(20 + $urandom % 200);
      while (osc === 1'b1 && osc_q === 1'b0) step(1);
      do_setup(6'(n));
      check(ovf, 1'b0, "overflow");
      read_all();
    end
    do_setup(6'h09);
    do_setup(6'h01);
    read_all();
    do_setup(6'h02);
    do_setup(6'h1A);
    step(5);
    tmr_en = 1'b1;
    step(40 + $urandom % 100);
    uf = 1'b1;
    step(1);
    uf = 1'b0;
    step(5);
    read_all();
    force_en = 1'b1;
    for (int h = 0; h < 2; h++) begin
      he = h[0];
      ie = 1'($urandom);
      do_setup(6'h28);
      step(5);
      force_lvl = 1'b1;
      step(3);
      force_lvl = 1'b0;
      step(10 + $urandom % 50);
      force_lvl = 1'b1;
      step(3);
      force_lvl = 1'b0;
      read_all();
      clk_en = 1'b0;
      hclr = 1'b1;
      fclr = 1'b1;
      step(2);
      check(req, 1'b1, "request frozen");
      clk_en = 1'b1;
      step(1);
      hclr = 1'b0;
      fclr = 1'b0;
      step(2);
    end
    report_and_stop();
  end

endmodule // rtf_top_bench
